// [hdl/sbr_pkg.sv]
// Shared constants, field positions, types and helpers for the burst read link.
package sbr_pkg;
	// Clock rate and derived cycle counts.
	localparam int CLK_MHZ = 40;
	localparam int CLK_PERIOD_NS = 25;
	localparam int CFG_TIME_NS = 2000;
	localparam int CFG_CYCLES = (CFG_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int RW_PULSE_NS = 100;
	localparam int RW_PULSE_CYCLES = (RW_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int T_KQV_NS = 17;
	localparam int T_SETUP_NS = 5;
	// Configuration word after reset and its field positions.
	localparam logic [15:0] CFG_RESET = 16'h3ddf;
	localparam int READ_SEL_BIT = 15;
	localparam int RSV_HI_BIT = 14;
	localparam int LAT_MSB = 13;
	localparam int LAT_LSB = 11;
	localparam int WAIT_POL_BIT = 10;
	localparam int HOLD2_BIT = 9;
	localparam int EARLY_BIT = 8;
	localparam int SEQ_BIT = 7;
	localparam int EDGE_BIT = 6;
	localparam int RSV_LO_BIT = 5;
	localparam int PINFN_BIT = 4;
	localparam int NOWRAP_BIT = 3;
	localparam int LEN_MSB = 2;
	localparam int LEN_LSB = 0;
	// Burst length codes and legal latency range.
	localparam logic [2:0] LEN_4 = 3'h1;
	localparam logic [2:0] LEN_8 = 3'h2;
	localparam logic [2:0] LEN_16 = 3'h3;
	localparam logic [2:0] LAT_MIN = 3'h2;
	localparam logic [2:0] LAT_DEFAULT = 3'h7;
	localparam logic [3:0] BLOCK16_MASK = 4'hf;
	// State machines of both ends.
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_LAT = 3'h1,
		ST_DATA = 3'h2,
		ST_WAITS = 3'h3,
		ST_END = 3'h4
	} sbr_dev_state_e;
	typedef enum logic [1:0] {
		H_IDLE = 2'h0,
		H_RUN = 2'h1,
		H_PULSE = 2'h2
	} sbr_host_state_e;
	// Forces reserved positions low and the burst type to sequential.
	function automatic logic [15:0] sbr_clean_cfg(input logic [15:0] v);
		logic [15:0] r;
		r = v;
		r[RSV_HI_BIT] = 1'b0;
		r[RSV_LO_BIT] = 1'b0;
		r[SEQ_BIT] = 1'b1;
		return r;
	endfunction
	// Words per burst; zero means continuous, as do unlisted codes.
	function automatic logic [4:0] sbr_burst_len(input logic [15:0] cfg);
		case (cfg[LEN_MSB:LEN_LSB])
			LEN_4: return 5'h04;
			LEN_8: return 5'h08;
			LEN_16: return 5'h10;
			default: return 5'h00;
		endcase
	endfunction
	// Latency in clocks; unlisted codes fall back to the default latency.
	function automatic logic [2:0] sbr_latency(input logic [15:0] cfg);
		if (cfg[LAT_MSB:LAT_LSB] < LAT_MIN) begin
			return LAT_DEFAULT;
		end
		return cfg[LAT_MSB:LAT_LSB];
	endfunction
endpackage

// [hdl/sbr_if.sv]
// Pin bundle between the flash end and the host end, with the shared ready/wait wire.
`timescale 1ns/1ps
interface sbr_if #(
	parameter int ADDR_W = 23
);
	logic k;
	logic ce_n;
	logic oe_n;
	logic latch_n;
	logic rp_n;
	logic [ADDR_W-1:0] addr;
	logic cfg_wr;
	logic [15:0] cfg_data;
	logic [15:0] dq;
	logic dq_oe;
	logic rw_dev_o;
	logic rw_dev_oe;
	logic rw_host_o;
	logic rw_host_oe;
	logic rw_line;

	// The wire is pulled up when nobody drives it.
	assign rw_line = rw_dev_oe ? rw_dev_o : (rw_host_oe ? rw_host_o : 1'b1);

	modport dev (
		input k, ce_n, oe_n, latch_n, rp_n, addr, cfg_wr, cfg_data, rw_line,
		output dq, dq_oe, rw_dev_o, rw_dev_oe
	);
	modport host (
		output k, ce_n, oe_n, latch_n, rp_n, addr, cfg_wr, cfg_data, rw_host_o, rw_host_oe,
		input dq, dq_oe, rw_line
	);
endinterface

// [hdl/sbr_flash_dev.sv]
// Flash end of the burst read link: configuration, burst sequencing and ready/wait pin.
`timescale 1ns/1ps
module sbr_flash_dev #(
	parameter int ADDR_W = 23
) (
	// Clock and reset.
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	// Link to the host.
	sbr_if.dev link,
	// Array read port, answered combinationally.
	output logic [ADDR_W-1:0] mem_addr_o,
	input wire logic [15:0] mem_data_i,
	// Status.
	output logic [15:0] cfg_o,
	output logic cfg_busy_o,
	output logic first_latch_sequence_restart_o
);
	logic [15:0] cfg_reg, cfg_next;
	logic [15:0] boot_reg, boot_next;
	logic low_seen_reg, low_seen_next;
	logic first_latch_sequence_reg, first_latch_sequence_next;
	sbr_pkg::sbr_dev_state_e state_reg, state_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic [1:0] start_lo_reg, start_lo_next;
	logic wait_pend_reg, wait_pend_next;
	logic [2:0] cnt_reg, cnt_next;
	logic [4:0] words_reg, words_next;
	logic hold_ph_reg, hold_ph_next;
	logic [15:0] eng_word_reg, eng_word_next;
	logic eng_inv_reg, eng_inv_next;
	logic [15:0] dq_reg, dq_next;
	logic inv_d_reg, inv_d_next;
	logic k_prev_reg;
	logic busy, sync_rd, hold2, act_edge, do_data, advance, wait_on;
	logic [4:0] len;
	logic [ADDR_W-1:0] wrap_mask, nxt_addr;

	assign busy = (boot_reg != 16'h0000);
	assign sync_rd = ~cfg_reg[sbr_pkg::READ_SEL_BIT];
	assign hold2 = cfg_reg[sbr_pkg::HOLD2_BIT];
	assign len = sbr_pkg::sbr_burst_len(cfg_reg);
	// A change of the clock pin towards the selected level is the active edge.
	assign act_edge = (link.k != k_prev_reg) && (link.k == cfg_reg[sbr_pkg::EDGE_BIT]);
	// Wrapped fixed bursts step only the bits inside the block; continuous ignores wrap.
	assign wrap_mask = ADDR_W'(len - 5'h01);
	always_comb begin
		if (len != 5'h00 && !cfg_reg[sbr_pkg::NOWRAP_BIT]) begin
			nxt_addr = (addr_reg & ~wrap_mask) | ((addr_reg + 1'b1) & wrap_mask);
		end else begin
			nxt_addr = addr_reg + 1'b1;
		end
	end

	// Configuration, boot hold-off and ready pulse detection.
	always_comb begin
		cfg_next = cfg_reg;
		boot_next = boot_reg;
		low_seen_next = low_seen_reg;
		first_latch_sequence_next = 1'b0;
		if (!link.rp_n) begin
			cfg_next = sbr_pkg::CFG_RESET;
			boot_next = 16'(sbr_pkg::CFG_CYCLES);
			low_seen_next = 1'b0;
		end else if (busy) begin
			boot_next = boot_reg - 16'h0001;
		end else begin
			if (link.cfg_wr) begin
				cfg_next = sbr_pkg::sbr_clean_cfg(link.cfg_data);
			end
			if (cfg_reg[sbr_pkg::PINFN_BIT]) begin
				if (!link.rw_line) begin
					low_seen_next = 1'b1;
				end else if (low_seen_reg) begin
					low_seen_next = 1'b0;
					first_latch_sequence_next = 1'b1;
				end
			end else begin
				low_seen_next = 1'b0;
			end
		end
	end

	// Registers of the configuration group.
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			cfg_reg <= sbr_pkg::CFG_RESET;
			boot_reg <= 16'(sbr_pkg::CFG_CYCLES);
			low_seen_reg <= 1'b0;
			first_latch_sequence_reg <= 1'b0;
		end else begin
			cfg_reg <= cfg_next;
			boot_reg <= boot_next;
			low_seen_reg <= low_seen_next;
			first_latch_sequence_reg <= first_latch_sequence_next;
		end
	end

	// The engine runs one active edge ahead of the pins so early wait can look forward.
	always_comb begin
		state_next = state_reg;
		addr_next = addr_reg;
		start_lo_next = start_lo_reg;
		wait_pend_next = wait_pend_reg;
		cnt_next = cnt_reg;
		words_next = words_reg;
		hold_ph_next = hold_ph_reg;
		eng_word_next = eng_word_reg;
		eng_inv_next = eng_inv_reg;
		dq_next = dq_reg;
		inv_d_next = inv_d_reg;
		do_data = 1'b0;
		advance = 1'b0;
		if (first_latch_sequence_reg || busy || !sync_rd || link.ce_n) begin
			state_next = sbr_pkg::ST_IDLE;
			eng_inv_next = 1'b1;
			inv_d_next = 1'b1;
		end else if (act_edge) begin
			dq_next = eng_word_reg;
			inv_d_next = eng_inv_reg;
			eng_inv_next = 1'b1;
			if (!link.latch_n) begin
				// Latch at the first active edge with chip and latch enables low.
				state_next = sbr_pkg::ST_LAT;
				addr_next = link.addr;
				start_lo_next = link.addr[1:0];
				cnt_next = sbr_pkg::sbr_latency(cfg_reg) - sbr_pkg::LAT_MIN;
				words_next = 5'h00;
				hold_ph_next = 1'b0;
				wait_pend_next = (link.addr[1:0] != 2'h0) &&
					(len == 5'h00 || cfg_reg[sbr_pkg::NOWRAP_BIT]);
			end else begin
				case (state_reg)
					sbr_pkg::ST_LAT: begin
						if (cnt_reg != 3'h0) begin
							cnt_next = cnt_reg - 3'h1;
						end else begin
							do_data = 1'b1;
						end
					end
					sbr_pkg::ST_DATA: begin
						do_data = 1'b1;
					end
					sbr_pkg::ST_WAITS: begin
						cnt_next = cnt_reg - 3'h1;
						if (cnt_reg == 3'h1) begin
							state_next = sbr_pkg::ST_DATA;
						end
					end
					default: begin
					end
				endcase
			end
		end
		// One data edge: show the word, then step once the hold is over.
		if (do_data) begin
			state_next = sbr_pkg::ST_DATA;
			eng_word_next = mem_data_i;
			eng_inv_next = 1'b0;
			hold_ph_next = hold2 & ~hold_ph_reg;
			advance = ~hold2 | hold_ph_reg;
		end
		if (advance) begin
			words_next = words_reg + 5'h01;
			addr_next = nxt_addr;
			if (len != 5'h00 && words_reg == len - 5'h01) begin
				state_next = sbr_pkg::ST_END;
			end else if (wait_pend_reg && (nxt_addr[3:0] & sbr_pkg::BLOCK16_MASK) == 4'h0) begin
				state_next = sbr_pkg::ST_WAITS;
				cnt_next = {1'b0, start_lo_reg};
				wait_pend_next = 1'b0;
			end
		end
	end

	// Registers of the engine group.
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			state_reg <= sbr_pkg::ST_IDLE;
			addr_reg <= '0;
			start_lo_reg <= 2'h0;
			wait_pend_reg <= 1'b0;
			cnt_reg <= 3'h0;
			words_reg <= 5'h00;
			hold_ph_reg <= 1'b0;
			eng_word_reg <= 16'h0000;
			eng_inv_reg <= 1'b1;
			dq_reg <= 16'h0000;
			inv_d_reg <= 1'b1;
			k_prev_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			addr_reg <= addr_next;
			start_lo_reg <= start_lo_next;
			wait_pend_reg <= wait_pend_next;
			cnt_reg <= cnt_next;
			words_reg <= words_next;
			hold_ph_reg <= hold_ph_next;
			eng_word_reg <= eng_word_next;
			eng_inv_reg <= eng_inv_next;
			dq_reg <= dq_next;
			inv_d_reg <= inv_d_next;
			k_prev_reg <= link.k;
		end
	end

	// Early mode shows the engine's view of the next slot, normal mode the current slot.
	assign wait_on = sync_rd & (cfg_reg[sbr_pkg::EARLY_BIT] ? eng_inv_reg : inv_d_reg);

	// Pin drivers: low while booting, wait output when so configured, else released.
	always_comb begin
		link.rw_dev_oe = 1'b0;
		link.rw_dev_o = 1'b0;
		if (busy) begin
			link.rw_dev_oe = 1'b1;
		end else if (!cfg_reg[sbr_pkg::PINFN_BIT]) begin
			link.rw_dev_oe = ~link.ce_n & ~link.oe_n;
			link.rw_dev_o = cfg_reg[sbr_pkg::WAIT_POL_BIT] ? wait_on : ~wait_on;
		end
	end

	assign link.dq = dq_reg;
	assign link.dq_oe = ~link.ce_n & ~link.oe_n & ~busy;
	assign mem_addr_o = addr_reg;
	assign cfg_o = cfg_reg;
	assign cfg_busy_o = busy;
	assign first_latch_sequence_restart_o = first_latch_sequence_reg;
endmodule

// [hdl/sbr_flash_host.sv]
// Host end of the burst read link: clock generation, burst control and word capture.
`timescale 1ns/1ps
module sbr_flash_host #(
	parameter int ADDR_W = 23,
	parameter int K_HALF = 2,
	parameter int DEPTH = 2
) (
	// Clock and reset.
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	// Link to the flash.
	sbr_if.host link,
	// Commands.
	input wire logic cfg_wr_i,
	input wire logic [15:0] cfg_data_i,
	input wire logic start_i,
	input wire logic [ADDR_W-1:0] start_addr_i,
	input wire logic stop_i,
	input wire logic retrigger_i,
	input wire logic rp_i,
	// Received words.
	output logic [15:0] word_o,
	output logic word_valid_o,
	input wire logic word_ready_i,
	// Status.
	output logic dev_ready_o,
	output logic busy_o,
	output logic [15:0] cfg_o
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int K_PERIOD_NS = 2 * K_HALF * sbr_pkg::CLK_PERIOD_NS;
	localparam logic NEED_HOLD2 = (K_PERIOD_NS <= sbr_pkg::T_KQV_NS + sbr_pkg::T_SETUP_NS);

	sbr_pkg::sbr_host_state_e state_reg, state_next;
	logic [15:0] cfg_reg, cfg_next;
	logic [7:0] div_reg, div_next;
	logic ph_reg, ph_next, ce_n_reg, ce_n_next, latch_n_reg, latch_n_next;
	logic rp_n_reg, wr_reg, wr_next, stop_reg, stop_next, skip_reg, skip_next;
	logic inv_prev_reg, inv_prev_next, cont_reg, cont_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic [15:0] wdata_reg, wdata_next;
	logic [4:0] left_reg, left_next;
	logic [7:0] pulse_reg, pulse_next;
	logic [15:0] fifo_mem [DEPTH];
	logic [AW-1:0] wptr_reg, rptr_reg;
	logic [AW:0] fcnt_reg;
	logic push, pop, tick, asserted, valid;

	assign tick = (div_reg == 8'h00);
	assign asserted = cfg_reg[sbr_pkg::WAIT_POL_BIT] ? link.rw_line : ~link.rw_line;
	assign valid = cfg_reg[sbr_pkg::EARLY_BIT] ? ~inv_prev_reg : ~asserted;
	assign pop = word_valid_o & word_ready_i;

	// Burst control, clock phase and capture decisions.
	always_comb begin
		state_next = state_reg;
		cfg_next = cfg_reg;
		div_next = tick ? 8'(K_HALF - 1) : div_reg - 8'h01;
		ph_next = ph_reg;
		ce_n_next = ce_n_reg;
		latch_n_next = latch_n_reg;
		wr_next = 1'b0;
		wdata_next = wdata_reg;
		stop_next = stop_reg | stop_i;
		skip_next = skip_reg;
		inv_prev_next = inv_prev_reg;
		cont_next = cont_reg;
		addr_next = addr_reg;
		left_next = left_reg;
		pulse_next = pulse_reg;
		push = 1'b0;
		case (state_reg)
			sbr_pkg::H_IDLE: begin
				if (rp_i) begin
					cfg_next = sbr_pkg::CFG_RESET;
				end else if (cfg_wr_i) begin
					wdata_next = sbr_pkg::sbr_clean_cfg(cfg_data_i);
					wdata_next[sbr_pkg::HOLD2_BIT] = cfg_data_i[sbr_pkg::HOLD2_BIT] | NEED_HOLD2;
					cfg_next = wdata_next;
					wr_next = 1'b1;
				end else if (retrigger_i && cfg_reg[sbr_pkg::PINFN_BIT] && link.rw_line) begin
					state_next = sbr_pkg::H_PULSE;
					pulse_next = 8'(sbr_pkg::RW_PULSE_CYCLES);
				end else if (start_i && !cfg_reg[sbr_pkg::PINFN_BIT] && link.rw_line) begin
					state_next = sbr_pkg::H_RUN;
					ce_n_next = 1'b0;
					latch_n_next = 1'b0;
					addr_next = start_addr_i;
					left_next = sbr_pkg::sbr_burst_len(cfg_reg);
					cont_next = (sbr_pkg::sbr_burst_len(cfg_reg) == 5'h00);
					stop_next = 1'b0;
					skip_next = 1'b0;
					inv_prev_next = 1'b1;
					ph_next = 1'b0;
				end
			end
			sbr_pkg::H_RUN: begin
				if (tick && !ph_reg) begin
					if (cont_reg ? stop_reg : (left_reg == 5'h00)) begin
						state_next = sbr_pkg::H_IDLE;
						ce_n_next = 1'b1;
					end else if (fcnt_reg < (AW + 1)'(DEPTH)) begin
						ph_next = 1'b1;
					end
				end else if (tick) begin
					// Sample half a period after the active edge.
					ph_next = 1'b0;
					latch_n_next = 1'b1;
					inv_prev_next = asserted;
					// The sample that follows the latch edge carries no data.
					if (latch_n_reg && valid) begin
						if (skip_reg) begin
							skip_next = 1'b0;
						end else begin
							push = 1'b1;
							skip_next = cfg_reg[sbr_pkg::HOLD2_BIT];
							left_next = left_reg - 5'h01;
						end
					end else if (!valid) begin
						skip_next = 1'b0;
					end
				end
			end
			sbr_pkg::H_PULSE: begin
				pulse_next = pulse_reg - 8'h01;
				if (pulse_reg == 8'h01) begin
					state_next = sbr_pkg::H_IDLE;
				end
			end
			default: begin
				state_next = sbr_pkg::H_IDLE;
			end
		endcase
	end

	// Registers of the control group.
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			state_reg <= sbr_pkg::H_IDLE;
			cfg_reg <= sbr_pkg::CFG_RESET;
			div_reg <= 8'h00;
			ph_reg <= 1'b0;
			ce_n_reg <= 1'b1;
			latch_n_reg <= 1'b1;
			rp_n_reg <= 1'b1;
			wr_reg <= 1'b0;
			wdata_reg <= 16'h0000;
			stop_reg <= 1'b0;
			skip_reg <= 1'b0;
			inv_prev_reg <= 1'b1;
			cont_reg <= 1'b0;
			addr_reg <= '0;
			left_reg <= 5'h00;
			pulse_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			cfg_reg <= cfg_next;
			div_reg <= div_next;
			ph_reg <= ph_next;
			ce_n_reg <= ce_n_next;
			latch_n_reg <= latch_n_next;
			rp_n_reg <= ~rp_i;
			wr_reg <= wr_next;
			wdata_reg <= wdata_next;
			stop_reg <= stop_next;
			skip_reg <= skip_next;
			inv_prev_reg <= inv_prev_next;
			cont_reg <= cont_next;
			addr_reg <= addr_next;
			left_reg <= left_next;
			pulse_reg <= pulse_next;
		end
	end

	// Word buffer; a full buffer holds the clock, which suspends the burst.
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
			fcnt_reg <= '0;
		end else begin
			if (push) begin
				fifo_mem[wptr_reg] <= link.dq;
				wptr_reg <= (wptr_reg == AW'(DEPTH - 1)) ? '0 : wptr_reg + 1'b1;
			end
			if (pop) begin
				rptr_reg <= (rptr_reg == AW'(DEPTH - 1)) ? '0 : rptr_reg + 1'b1;
			end
			fcnt_reg <= fcnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end

	assign word_o = fifo_mem[rptr_reg];
	assign word_valid_o = (fcnt_reg != '0);
	assign link.k = ph_reg ? cfg_reg[sbr_pkg::EDGE_BIT] : ~cfg_reg[sbr_pkg::EDGE_BIT];
	assign link.ce_n = ce_n_reg;
	assign link.oe_n = ce_n_reg;
	assign link.latch_n = latch_n_reg;
	assign link.rp_n = rp_n_reg;
	assign link.addr = addr_reg;
	assign link.cfg_wr = wr_reg;
	assign link.cfg_data = wdata_reg;
	assign link.rw_host_o = 1'b0;
	assign link.rw_host_oe = (state_reg == sbr_pkg::H_PULSE);
	assign dev_ready_o = link.rw_line & rp_n_reg;
	assign busy_o = (state_reg != sbr_pkg::H_IDLE);
	assign cfg_o = cfg_reg;
endmodule

// [test/sbr_link_chk.sv]
// Concurrent checks on the pins that join the flash end and the host end.
`timescale 1ns/1ps
module sbr_link_chk #(
	parameter int ADDR_W = 23
) (
	// Clock and reset.
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	// Host driven pins.
	input wire logic k,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic latch_n,
	input wire logic rp_n,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic cfg_wr,
	input wire logic [15:0] cfg_data,
	input wire logic rw_host_o,
	input wire logic rw_host_oe,
	// Flash driven pins and the resolved wire.
	input wire logic [15:0] dq,
	input wire logic dq_oe,
	input wire logic rw_dev_o,
	input wire logic rw_dev_oe,
	input wire logic rw_line
);
	logic [15:0] cfg_m;
	logic [15:0] dq_d;
	logic [6:0] boot_cnt;
	logic [3:0] since_chg;
	logic [1:0] act_h;
	logic k_d;
	logic act;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);

	// An active clock edge is a change of k to the level chosen in the mirrored setting.
	assign act = (k != k_d) && (k == cfg_m[sbr_pkg::EDGE_BIT]);

	// Mirror of the setting word, boot time and data change spacing.
	always_ff @(posedge clk_sys_i) begin
		k_d <= k;
		dq_d <= dq;
		if (sys_rst_i) begin
			act_h <= 2'h0;
			since_chg <= 4'hf;
		end else begin
			act_h <= {act_h[0], act};
			since_chg <= (dq != dq_d) ? 4'h1 :
				((since_chg == 4'hf) ? 4'hf : since_chg + 4'h1);
		end
		if (sys_rst_i || !rp_n) begin
			cfg_m <= sbr_pkg::CFG_RESET;
			boot_cnt <= 7'(sbr_pkg::CFG_CYCLES);
		end else begin
			if (boot_cnt != 7'h00) begin
				boot_cnt <= boot_cnt - 7'h01;
			end
			if (cfg_wr && boot_cnt == 7'h00) begin
				cfg_m <= cfg_data;
			end
		end
	end

	sequence latch_s;
		$fell(latch_n) && !ce_n && !cfg_m[sbr_pkg::PINFN_BIT];
	endsequence
	sequence idle_s;
		!cfg_m[sbr_pkg::PINFN_BIT] throughout ce_n [*3];
	endsequence
	property lat_wait_p;
		latch_s |-> ##[1:10] (rw_line == cfg_m[sbr_pkg::WAIT_POL_BIT]);
	endproperty

	boot_pin_low_a: assert property (boot_cnt > 7'h02 && $past(boot_cnt) > 7'h02
		|-> rw_dev_oe && !rw_dev_o)
		else $error("Ready pin released during boot");
	boot_dq_off_a: assert property (boot_cnt > 7'h02 && $past(boot_cnt) > 7'h02 |-> !dq_oe)
		else $error("Data driven during boot");
	rp_pin_low_a: assert property (!rp_n |-> ##[1:2] (rw_dev_oe && !rw_dev_o))
		else $error("Ready pin not low after reset pulse");
	dq_gate_a: assert property (ce_n |-> !dq_oe)
		else $error("Data driven while deselected");
	data_valid_a: assert property (!ce_n && !cfg_m[sbr_pkg::PINFN_BIT] && boot_cnt == 7'h00
		&& rw_dev_oe && rw_dev_o != cfg_m[sbr_pkg::WAIT_POL_BIT] |-> dq_oe)
		else $error("Wait off but data not driven");
	latency_wait_a: assert property (lat_wait_p)
		else $error("No wait during latency");
	idle_wait_a: assert property (idle_s
		|-> !(rw_dev_oe && rw_dev_o == cfg_m[sbr_pkg::WAIT_POL_BIT]))
		else $error("Wait asserted while deselected");
	edge_sync_a: assert property ($changed(dq) && !ce_n && $past(!ce_n) && rp_n |-> |act_h)
		else $error("Data changed away from active edge");
	hold_two_a: assert property ($changed(dq) && !ce_n && $past(!ce_n)
		&& cfg_m[sbr_pkg::HOLD2_BIT] |-> since_chg > 4'h5)
		else $error("Word held less than two clocks");
endmodule

// [test/tb_sync_burst_read_config.sv]
// Self-checking bench joining the flash end and the host end over the shared link.
`timescale 1ns/1ps
module tb_sync_burst_read_config;
	logic clk_sys_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic cfg_wr, start, stop, retrig, rp, ready;
	logic discard = 1'b0;
	logic hit;
	logic [15:0] cfg_data;
	logic [15:0] cfg;
	logic [22:0] saddr;
	logic [22:0] mem_addr;
	logic [15:0] mem_data, word, dev_cfg, host_cfg;
	logic word_valid, dev_ready, busy, cfg_busy, first_latch_sequence;
	logic [15:0] exp_q[$];
	logic [2:0] lcode[4] = '{3'h1, 3'h2, 3'h3, 3'h7};
	logic [4:0] blen[4] = '{5'h04, 5'h08, 5'h10, 5'h00};
	logic [3:0] offs[6] = '{4'h1, 4'h2, 4'h3, 4'h7, 4'hd, 4'hf};
	int err_count = 0;
	int n_compared = 0;

	sbr_if #(.ADDR_W(23)) link ();

	// Clock of 25 ns period.
	always #12.5 clk_sys_i = ~clk_sys_i;

	// Array model: each word is a scrambled copy of its own address.
	assign mem_data = mem_addr[15:0] ^ 16'h5a3c;

	sbr_flash_dev #(.ADDR_W(23)) i_sbr_flash_dev (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
		.link(link), .mem_addr_o(mem_addr), .mem_data_i(mem_data), .cfg_o(dev_cfg),
		.cfg_busy_o(cfg_busy), .first_latch_sequence_restart_o(first_latch_sequence));
	sbr_flash_host #(.ADDR_W(23), .K_HALF(2), .DEPTH(2)) i_sbr_flash_host (.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i), .link(link), .cfg_wr_i(cfg_wr), .cfg_data_i(cfg_data),
		.start_i(start), .start_addr_i(saddr), .stop_i(stop), .retrigger_i(retrig), .rp_i(rp),
		.word_o(word), .word_valid_o(word_valid), .word_ready_i(ready), .dev_ready_o(dev_ready),
		.busy_o(busy), .cfg_o(host_cfg));
	sbr_link_chk #(.ADDR_W(23)) i_sbr_link_chk (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
		.k(link.k), .ce_n(link.ce_n), .oe_n(link.oe_n), .latch_n(link.latch_n), .rp_n(link.rp_n),
		.addr(link.addr), .cfg_wr(link.cfg_wr), .cfg_data(link.cfg_data),
		.rw_host_o(link.rw_host_o), .rw_host_oe(link.rw_host_oe), .dq(link.dq),
		.dq_oe(link.dq_oe), .rw_dev_o(link.rw_dev_o), .rw_dev_oe(link.rw_dev_oe),
		.rw_line(link.rw_line));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results;
		$display("Compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask

	// Address of the i-th word: wrapped bursts only move the low bits.
	function automatic logic [22:0] exp_addr(input logic [22:0] s, input logic [4:0] len,
		input logic nowrap, input int i);
		logic [22:0] m;
		m = {18'h0, len} - 23'h1;
		if (len == 5'h00 || nowrap) begin
			return s + 23'(i);
		end
		return (s & ~m) | ((s + 23'(i)) & m);
	endfunction

	task automatic wait_ready;
		for (int t = 0; t < 300 && dev_ready !== 1'b1; t++) cyc(1);
		check({15'h0, dev_ready}, 16'h0001);
	endtask

	task automatic write_cfg(input logic [15:0] v);
		cfg_data = v;
		cfg_wr = 1'b1;
		cyc(1);
		cfg_wr = 1'b0;
		cyc(4);
		check(dev_cfg, (v & 16'hbfdf) | 16'h0080);
		check(host_cfg, (v & 16'hbfdf) | 16'h0080);
	endtask

	// Notes the expected words, starts one burst and ends it.
	task automatic burst(input logic [22:0] s, input logic [4:0] len, input logic nowrap, input int n);
		logic [22:0] a;
		for (int i = 0; i < n; i++) begin
			a = exp_addr(s, len, nowrap, i);
			exp_q.push_back(a[15:0] ^ 16'h5a3c);
		end
		saddr = s;
		start = 1'b1;
		cyc(1);
		start = 1'b0;
		for (int t = 0; t < 5000 && exp_q.size() != 0; t++) cyc(1);
		// A continuous burst runs on until stopped, so its extra words are dropped.
		discard = (len == 5'h00);
		check(16'(exp_q.size()), 16'h0000);
		exp_q.delete();
		if (len == 5'h00) begin
			stop = 1'b1;
			cyc(1);
			stop = 1'b0;
		end
		for (int t = 0; t < 300 && busy !== 1'b0; t++) cyc(1);
		check({15'h0, busy}, 16'h0000);
		cyc(20);
		discard = 1'b0;
	endtask

	// Receiver stalls at random.
	always @(posedge clk_sys_i) begin
		#1;
		ready = ($urandom_range(3) != 0);
	end

	// Compares each received word with the oldest note.
	always @(posedge clk_sys_i) begin
		if (!sys_rst_i && word_valid === 1'b1 && ready && !discard) begin
			if (exp_q.size() == 0) begin
				n_compared++;
				err_count++;
				$display("Error at %0t: seen %h expected %h", $time, word, 16'h0000);
			end else begin
				check(word, exp_q.pop_front());
			end
		end
	end

	// Watchdog against a hang.
	initial begin
		repeat (40000) @(posedge clk_sys_i);
		err_count++;
		results;
	end

	// Main sequence.
	initial begin
		void'($urandom(55296));
		{cfg_wr, start, stop, retrig, rp} = 5'h00;
		cfg_data = 16'h0000;
		saddr = 23'h000000;
		cyc(2);
		sys_rst_i = 1'b0;
		check(dev_cfg, sbr_pkg::CFG_RESET);
		check({15'h0, cfg_busy}, 16'h0001);
		wait_ready;
		// Ready function: a start is refused and a retrigger restarts the first latch.
		start = 1'b1;
		cyc(1);
		start = 1'b0;
		cyc(2);
		check({15'h0, busy}, 16'h0000);
		retrig = 1'b1;
		cyc(1);
		retrig = 1'b0;
		hit = 1'b0;
		for (int t = 0; t < 60; t++) begin
			cyc(1);
			if (first_latch_sequence === 1'b1) hit = 1'b1;
		end
		check({15'h0, hit}, 16'h0001);
		wait_ready;
		write_cfg(16'h606a);
		// Every length and six start offsets, with random wrap setting and timing fields.
		for (int i = 0; i < 12; i++) begin
			cfg = {2'b00, 3'(3 + $urandom_range(4)), 1'($urandom), 1'($urandom), 1'($urandom), 1'b1,
				1'($urandom), 2'b00, 1'($urandom), lcode[i % 4]};
			write_cfg(cfg);
			wait_ready;
			if (i >= 7 && lcode[i % 4] == 3'h7) begin
				burst({19'h07fff, offs[i % 6]}, 5'h00, cfg[3], 24);
			end else begin
				burst({19'($urandom), offs[i % 6]}, blen[i % 4], cfg[3],
					(blen[i % 4] == 5'h00) ? 24 : int'(blen[i % 4]));
			end
		end
		// A reset pulse restores the default setting.
		rp = 1'b1;
		cyc(3);
		rp = 1'b0;
		cyc(2);
		check(dev_cfg, sbr_pkg::CFG_RESET);
		wait_ready;
		results;
	end
endmodule
